// file: pli_pkg.sv
package pli_pkg;

  localparam int CLK_HZ = 25_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int STRETCH_A_MS = 28;
  localparam int STRETCH_B_MS = 60;
  localparam int STRETCH_C_MS = 100;
  localparam int STRETCH_A_CYC = STRETCH_A_MS * CYC_PER_MS;
  localparam int STRETCH_B_CYC = STRETCH_B_MS * CYC_PER_MS;
  localparam int STRETCH_C_CYC = STRETCH_C_MS * CYC_PER_MS;
  localparam int BLINK_TICK_MS = 8;
  localparam int BLINK_TICK_CYC = BLINK_TICK_MS * CYC_PER_MS;

  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;
  localparam logic [4:0] ADDR_MODE = 5'h1b;
  localparam logic [4:0] ADDR_FUNC = 5'h1c;
  localparam logic [4:0] ADDR_BLINK = 5'h1d;

  localparam logic [15:0] MODE_RESET = 16'h0001;
  localparam logic [15:0] MODE_RW_MASK = 16'hfcfd;
  localparam logic [15:0] FUNC_RESET = 16'hf4f0;
  localparam logic [1:0] BLINK_SEL_RESET = 2'h0;
  localparam logic [5:0] BLINK_DIV_RESET = 6'h1f;
  localparam logic [7:0] BLINK_PAT_RESET = 8'h55;

  localparam int MODE_PAIR_SPEED_BIT = 15;
  localparam int MODE_PAIR_LINK_BIT = 14;
  localparam int MODE_EXT_ACT_BIT = 13;
  localparam int MODE_EXT_LINK_BIT = 12;
  localparam int MODE_EXT_FAST_BIT = 11;
  localparam int MODE_EXT_GIG_BIT = 10;
  localparam int MODE_PAUSE_LSB = 4;
  localparam int MODE_DUR_LSB = 2;
  localparam int MODE_STRETCH_BIT = 0;

  localparam int FUNC_ACT_LSB = 12;
  localparam int FUNC_LINK_LSB = 8;
  localparam int FUNC_FAST_LSB = 4;
  localparam int FUNC_GIG_LSB = 0;

  localparam int BLINK_SEL_LSB = 14;
  localparam int BLINK_DIV_LSB = 8;
  localparam int BLINK_PAT_LSB = 0;

  localparam logic [1:0] LAMP_LINK = 2'h0;
  localparam logic [1:0] LAMP_ACT = 2'h1;
  localparam logic [1:0] LAMP_GIG = 2'h2;
  localparam logic [1:0] LAMP_FAST = 2'h3;

  localparam logic [1:0] DUR_A = 2'h0;
  localparam logic [1:0] DUR_B = 2'h1;
  localparam logic [1:0] DUR_C = 2'h2;

  localparam logic [1:0] SPEED_10 = 2'h0;
  localparam logic [1:0] SPEED_100 = 2'h1;
  localparam logic [1:0] SPEED_1000 = 2'h2;

  localparam logic [3:0] FN_GIG = 4'h0;
  localparam logic [3:0] FN_FAST = 4'h1;
  localparam logic [3:0] FN_SLOW = 4'h2;
  localparam logic [3:0] FN_GIG_ON_FAST_BLINK = 4'h3;
  localparam logic [3:0] FN_LINK = 4'h4;
  localparam logic [3:0] FN_TX = 4'h5;
  localparam logic [3:0] FN_RX = 4'h6;
  localparam logic [3:0] FN_ACT = 4'h7;
  localparam logic [3:0] FN_DUPLEX = 4'h8;
  localparam logic [3:0] FN_COL = 4'h9;
  localparam logic [3:0] FN_LINK_ACT = 4'ha;
  localparam logic [3:0] FN_LINK_RX = 4'hb;
  localparam logic [3:0] FN_DUPLEX_COL = 4'hc;
  localparam logic [3:0] FN_BLINK = 4'hd;
  localparam logic [3:0] FN_ON = 4'he;
  localparam logic [3:0] FN_OFF = 4'hf;
  localparam logic [3:0] XFN_SLOW_FAST = 4'h0;
  localparam logic [3:0] XFN_GIG_ACT = 4'h4;
  localparam logic [3:0] XFN_SLOW_FAST_ACT = 4'h5;

  typedef struct packed {
    logic [1:0] speed;
    logic link_up;
    logic full_duplex;
    logic tx_active;
    logic rx_active;
    logic collision;
  } pli_status_s;

  typedef struct packed {
    logic gig_speed_lamp;
    logic fast_speed_lamp;
    logic link_lamp;
    logic activity_lamp;
  } pli_lamps_s;

endpackage

// file: pli_stretch.sv
`timescale 1ns/1ps
`default_nettype none
module pli_stretch #(
  parameter int CNT_W = 22
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic enable,
  input wire logic event_in,
  input wire logic [CNT_W-1:0] hold_cyc,
  output logic stretched_q
);
  import pli_pkg::*;

  logic [CNT_W-1:0] cnt_q;

  // Reload on every active cycle so the hold counts from the event's end
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= '0;
    end else if (event_in && enable) begin
      cnt_q <= hold_cyc;
    end else if (!enable) begin
      cnt_q <= '0;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      stretched_q <= 1'b0;
    end else begin
      stretched_q <= event_in | (cnt_q != '0);
    end
  end
endmodule
`default_nettype wire

// file: pli_blink.sv
`timescale 1ns/1ps
`default_nettype none
module pli_blink (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic tick,
  input wire logic [5:0] divide,
  input wire logic [7:0] pattern,
  input wire logic [3:0] pause,
  output logic blink_q
);
  import pli_pkg::*;

  typedef enum logic {PLI_SHIFT, PLI_PAUSE} pli_blink_e;

  pli_blink_e state_q;
  logic [5:0] div_q;
  logic [2:0] bit_q;
  logic [3:0] pause_q;
  logic step;

  assign step = tick && (div_q >= divide);

  // A step lasts divide+1 base ticks
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_q <= '0;
    end else if (step) begin
      div_q <= '0;
    end else if (tick) begin
      div_q <= div_q + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= PLI_SHIFT;
      bit_q <= '0;
      pause_q <= '0;
    end else if (step) begin
      case (state_q)
        PLI_SHIFT: begin
          if (bit_q == 3'h7 && pause != 4'h0) begin
            state_q <= PLI_PAUSE;
            pause_q <= 4'h1;
          end
          bit_q <= bit_q + 1'b1;
        end
        PLI_PAUSE: begin
          if (pause_q >= pause) begin
            state_q <= PLI_SHIFT;
          end
          pause_q <= pause_q + 1'b1;
        end
        default: state_q <= PLI_SHIFT;
      endcase
    end
  end

  // Output holds its last bit through the pause
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      blink_q <= 1'b0;
    end else if (state_q == PLI_SHIFT) begin
      blink_q <= pattern[bit_q];
    end
  end
endmodule
`default_nettype wire

// file: pli_led_ctrl.sv
// Notes on behaviour
// - Bit 15 pairs speed lamps two-colour
// - Bit 14 pairs link and activity lamps
// - First lamp of pair masked by second
// - Bits 13..10 select extended function encodings
// - Function from extended bit plus selector
// - Duration codes: 28, 60, 100 ms
// - Bit 0 enables stretch, resets on
// - Bits 7:4 set blink pause steps
// - Codes 0-3 show link speed
// - Codes 4-9 show link, traffic, duplex, collision
// - Codes a,b: link on, traffic blink
// - Code c duplex/collision; d,e,f forced
// - Extended codes 0, 4, 5 defined
// - Bits 15:14 pick blink settings copy
// - Bits 13:8 divider, resets 0x1f
// - Bits 7:0 pattern, resets 0x55
`timescale 1ns/1ps
`default_nettype none
module pli_led_ctrl #(
  parameter int STRETCH_A_CYC = pli_pkg::STRETCH_A_CYC,
  parameter int STRETCH_B_CYC = pli_pkg::STRETCH_B_CYC,
  parameter int STRETCH_C_CYC = pli_pkg::STRETCH_C_CYC,
  parameter int BLINK_TICK_CYC = pli_pkg::BLINK_TICK_CYC
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [pli_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [pli_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [pli_pkg::DATA_W-1:0] reg_rdata,
  input wire pli_pkg::pli_status_s status,
  output pli_pkg::pli_lamps_s lamps
);
  import pli_pkg::*;

  localparam int HOLD_W = $clog2(STRETCH_C_CYC + 1);
  localparam int TICK_W = $clog2(BLINK_TICK_CYC + 1);

  logic [15:0] mode_q;
  logic [15:0] func_q;
  logic [1:0] sel_q;
  logic [5:0] div_q [4];
  logic [7:0] pat_q [4];
  logic [15:0] rdata_q;
  logic [TICK_W-1:0] tick_cnt_q;
  logic tick;
  logic [HOLD_W-1:0] hold_cyc;
  logic stretch_en;
  logic tx_s;
  logic rx_s;
  logic col_s;
  pli_status_s st;
  logic [3:0] blink;
  logic f_gig;
  logic f_fast;
  logic f_link;
  logic f_act;
  logic wr_mode;
  logic wr_func;
  logic wr_blink;
  logic [1:0] wsel;
  logic [2:0] hit;
  logic [15:0] rdata_d;
  logic [1:0] dur;
  logic [3:0] pause;
  logic [3:0] ext_sel;
  logic [3:0][3:0] code_sel;

  function automatic logic lamp_fn(
    input logic ext,
    input logic [3:0] code,
    input pli_status_s s,
    input logic blk
  );
    logic gig;
    logic fast;
    logic slow;
    logic act;
    logic on;
    gig = s.link_up && (s.speed == SPEED_1000);
    fast = s.link_up && (s.speed == SPEED_100);
    slow = s.link_up && (s.speed == SPEED_10);
    act = s.tx_active || s.rx_active;
    on = 1'b0;
    if (ext) begin
      case (code)
        XFN_SLOW_FAST: on = slow || fast;
        XFN_GIG_ACT: on = gig && (act ? blk : 1'b1);
        XFN_SLOW_FAST_ACT: on = (slow || fast) && (act ? blk : 1'b1);
        default: on = 1'b0;
      endcase
    end else begin
      case (code)
        FN_GIG: on = gig;
        FN_FAST: on = fast;
        FN_SLOW: on = slow;
        FN_GIG_ON_FAST_BLINK: on = gig || (fast && blk);
        FN_LINK: on = s.link_up;
        FN_TX: on = s.tx_active;
        FN_RX: on = s.rx_active;
        FN_ACT: on = act;
        FN_DUPLEX: on = s.full_duplex;
        FN_COL: on = s.collision;
        FN_LINK_ACT: on = s.link_up && (act ? blk : 1'b1);
        FN_LINK_RX: on = s.link_up && (s.rx_active ? blk : 1'b1);
        FN_DUPLEX_COL: on = s.collision ? blk : s.full_duplex;
        FN_BLINK: on = blk;
        FN_ON: on = 1'b1;
        FN_OFF: on = 1'b0;
        default: on = 1'b0;
      endcase
    end
    return on;
  endfunction

  // One decoder for strobes and readback, so both agree on the map
  function automatic logic [2:0] addr_hit(
    input logic [ADDR_W-1:0] addr
  );
    logic [2:0] sel;
    sel = 3'h0;
    if (addr == ADDR_MODE) begin
      sel = 3'h1;
    end else if (addr == ADDR_FUNC) begin
      sel = 3'h2;
    end else if (addr == ADDR_BLINK) begin
      sel = 3'h4;
    end
    return sel;
  endfunction

  assign hit = addr_hit(reg_addr);
  assign wr_mode = reg_wr && hit[0];
  assign wr_func = reg_wr && hit[1];
  assign wr_blink = reg_wr && hit[2];
  assign wsel = reg_wdata[BLINK_SEL_LSB +: 2];

  // Reserved mode bits never store, so they read zero
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_q <= MODE_RESET;
    end else if (wr_mode) begin
      mode_q <= reg_wdata & MODE_RW_MASK;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      func_q <= FUNC_RESET;
    end else if (wr_func) begin
      func_q <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sel_q <= BLINK_SEL_RESET;
    end else if (wr_blink) begin
      sel_q <= wsel;
    end
  end

  // The write lands in the copy named by the select field it carries
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 4; i++) begin
        div_q[i] <= BLINK_DIV_RESET;
        pat_q[i] <= BLINK_PAT_RESET;
      end
    end else if (wr_blink) begin
      div_q[wsel] <= reg_wdata[BLINK_DIV_LSB +: 6];
      pat_q[wsel] <= reg_wdata[BLINK_PAT_LSB +: 8];
    end
  end

  // Read data valid only in the cycle after the strobe
  always_comb begin
    rdata_d = '0;
    if (reg_rd && hit[0]) begin
      rdata_d = mode_q;
    end else if (reg_rd && hit[1]) begin
      rdata_d = func_q;
    end else if (reg_rd && hit[2]) begin
      rdata_d = {sel_q, div_q[sel_q], pat_q[sel_q]};
    end
  end

  // Idle and unmapped reads return zero
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // One base tick shared by all blink generators
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_cnt_q <= '0;
    end else if (tick) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
    end
  end

  assign tick = (tick_cnt_q == TICK_W'(BLINK_TICK_CYC - 1));

  assign dur = mode_q[MODE_DUR_LSB +: 2];
  assign pause = mode_q[MODE_PAUSE_LSB +: 4];

  // Reserved code falls back to the shortest hold
  always_comb begin
    case (dur)
      DUR_A: hold_cyc = HOLD_W'(STRETCH_A_CYC);
      DUR_B: hold_cyc = HOLD_W'(STRETCH_B_CYC);
      DUR_C: hold_cyc = HOLD_W'(STRETCH_C_CYC);
      default: hold_cyc = HOLD_W'(STRETCH_A_CYC);
    endcase
  end

  assign stretch_en = mode_q[MODE_STRETCH_BIT];

  pli_stretch #(.CNT_W(HOLD_W)) u_tx_stretch (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .enable(stretch_en),
    .event_in(status.tx_active),
    .hold_cyc(hold_cyc),
    .stretched_q(tx_s)
  );

  pli_stretch #(.CNT_W(HOLD_W)) u_rx_stretch (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .enable(stretch_en),
    .event_in(status.rx_active),
    .hold_cyc(hold_cyc),
    .stretched_q(rx_s)
  );

  pli_stretch #(.CNT_W(HOLD_W)) u_col_stretch (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .enable(stretch_en),
    .event_in(status.collision),
    .hold_cyc(hold_cyc),
    .stretched_q(col_s)
  );

  always_comb begin
    st = status;
    st.tx_active = tx_s;
    st.rx_active = rx_s;
    st.collision = col_s;
  end

  for (genvar g = 0; g < 4; g++) begin : g_blink
    pli_blink u_blink (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .tick(tick),
      .divide(div_q[g]),
      .pattern(pat_q[g]),
      .pause(pause),
      .blink_q(blink[g])
    );
  end

  // Lamp order matches the blink select field, so one index serves both
  always_comb begin
    ext_sel[LAMP_LINK] = mode_q[MODE_EXT_LINK_BIT];
    ext_sel[LAMP_ACT] = mode_q[MODE_EXT_ACT_BIT];
    ext_sel[LAMP_GIG] = mode_q[MODE_EXT_GIG_BIT];
    ext_sel[LAMP_FAST] = mode_q[MODE_EXT_FAST_BIT];
    code_sel[LAMP_LINK] = func_q[FUNC_LINK_LSB +: 4];
    code_sel[LAMP_ACT] = func_q[FUNC_ACT_LSB +: 4];
    code_sel[LAMP_GIG] = func_q[FUNC_GIG_LSB +: 4];
    code_sel[LAMP_FAST] = func_q[FUNC_FAST_LSB +: 4];
  end

  assign f_gig = lamp_fn(ext_sel[LAMP_GIG], code_sel[LAMP_GIG], st, blink[LAMP_GIG]);
  assign f_fast = lamp_fn(ext_sel[LAMP_FAST], code_sel[LAMP_FAST], st, blink[LAMP_FAST]);
  assign f_link = lamp_fn(ext_sel[LAMP_LINK], code_sel[LAMP_LINK], st, blink[LAMP_LINK]);
  assign f_act = lamp_fn(ext_sel[LAMP_ACT], code_sel[LAMP_ACT], st, blink[LAMP_ACT]);

  // Pairing keeps the two dies of a bicolour lamp from lighting together
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      lamps <= '0;
    end else begin
      lamps.gig_speed_lamp <= mode_q[MODE_PAIR_SPEED_BIT] ? (f_gig & ~f_fast) : f_gig;
      lamps.fast_speed_lamp <= f_fast;
      lamps.link_lamp <= mode_q[MODE_PAIR_LINK_BIT] ? (f_link & ~f_act) : f_link;
      lamps.activity_lamp <= f_act;
    end
  end
endmodule
`default_nettype wire

// file: pli_led_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none
module pli_led_ctrl_chk
  import pli_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire pli_status_s status,
  input wire pli_lamps_s lamps
);
  logic [15:0] mode_q;
  logic [15:0] func_q;
  // Shadow copies, so lamp checks follow what software set
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_q <= MODE_RESET;
      func_q <= FUNC_RESET;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_MODE) mode_q <= reg_wdata & MODE_RW_MASK;
      if (reg_addr == ADDR_FUNC) func_q <= reg_wdata;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  property p_mode_rd;
    reg_rd && reg_addr == ADDR_MODE |=> reg_rdata == $past(mode_q);
  endproperty
  a_mode_rd: assert property (p_mode_rd) else $error("mode readback wrong");
  property p_func_rd;
    reg_rd && reg_addr == ADDR_FUNC |=> reg_rdata == $past(func_q);
  endproperty
  a_func_rd: assert property (p_func_rd) else $error("function readback wrong");
  property p_pair_speed;
    $past(mode_q[15]) && lamps.fast_speed_lamp |-> !lamps.gig_speed_lamp;
  endproperty
  a_pair_speed: assert property (p_pair_speed) else $error("speed pair both lit");
  property p_pair_link;
    $past(mode_q[14]) && lamps.activity_lamp |-> !lamps.link_lamp;
  endproperty
  a_pair_link: assert property (p_pair_link) else $error("link pair both lit");
  property p_link_fn;
    func_q[11:8] == FN_LINK && !mode_q[12] && !mode_q[14]
      |=> lamps.link_lamp == $past(status.link_up);
  endproperty
  a_link_fn: assert property (p_link_fn) else $error("link lamp wrong");
  property p_forced_on;
    func_q[3:0] == FN_ON && !mode_q[10] && !mode_q[15] |=> lamps.gig_speed_lamp;
  endproperty
  a_forced_on: assert property (p_forced_on) else $error("forced lamp dark");
  property p_speed_fast;
    func_q[7:4] == FN_FAST && !mode_q[11] |=> lamps.fast_speed_lamp ==
      ($past(status.link_up) && $past(status.speed) == SPEED_100);
  endproperty
  a_speed_fast: assert property (p_speed_fast) else $error("speed lamp wrong");
  property p_ext_slow;
    mode_q[11] && func_q[7:4] == XFN_SLOW_FAST |=> lamps.fast_speed_lamp ==
      ($past(status.link_up) &&
      ($past(status.speed) == SPEED_10 || $past(status.speed) == SPEED_100));
  endproperty
  a_ext_slow: assert property (p_ext_slow) else $error("extended lamp wrong");
  // Short pulse must stay visible for a while once stretched
  property p_stretch;
    func_q[15:12] == FN_TX && !mode_q[13] && !mode_q[14] && mode_q[0] &&
      $past(status.tx_active, 2) && !$past(status.tx_active) |=> lamps.activity_lamp [*3];
  endproperty
  a_stretch: assert property (p_stretch) else $error("pulse not stretched");
endmodule
`default_nettype wire

// file: pli_lamp_model.sv
`timescale 1ns/1ps
`default_nettype none
module pli_lamp_model
  import pli_pkg::*;
(
  input wire logic ref_clk,
  input wire logic clear,
  input wire pli_lamps_s lamps,
  output logic [3:0][7:0] on_cnt,
  output logic [3:0][7:0] rise_cnt
);
  logic [3:0] prev_q;
  // Counts lit cycles and turn-ons, as an eye on the lamps would
  always_ff @(posedge ref_clk) begin
    prev_q <= lamps;
    for (int i = 0; i < 4; i++) begin
      on_cnt[i] <= clear ? 8'h00 : on_cnt[i] + 8'(lamps[i]);
      rise_cnt[i] <= clear ? 8'h00 : rise_cnt[i] + 8'(lamps[i] && !prev_q[i]);
    end
  end
endmodule
`default_nettype wire

// file: pli_led_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin bad_count++; \
  $display("mismatch at %0t got %h exp %h", $time, (a), (b)); end end
module pli_led_ctrl_tb;
  import pli_pkg::*;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  pli_status_s status = '0;
  pli_lamps_s lamps;
  logic clear = 1'b0;
  logic [3:0][7:0] on_cnt;
  logic [3:0][7:0] rise_cnt;
  int bad_count = 0;
  int samples_checked = 0;
  logic [4:0][15:0] modes = {16'h0000, 16'h000d, 16'h0009, 16'h0005, 16'h0001};
  logic [4:0][7:0] holds = {8'h01, 8'h05, 8'h0d, 8'h09, 8'h05};
  logic [2:0][3:0] xc = {XFN_SLOW_FAST_ACT, XFN_GIG_ACT, XFN_SLOW_FAST};
  initial forever #20 ref_clk = ~ref_clk;
  // Short stretch and tick counts keep the run brief
  pli_led_ctrl #(.STRETCH_A_CYC(4), .STRETCH_B_CYC(8), .STRETCH_C_CYC(12),
    .BLINK_TICK_CYC(2)) i_dut (.ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .status(status), .lamps(lamps));
  pli_lamp_model i_lamps (.ref_clk(ref_clk), .clear(clear), .lamps(lamps),
    .on_cnt(on_cnt), .rise_cnt(rise_cnt));
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
  endtask
  task automatic try(input logic [15:0] f, input int i, input logic e);
    wr(ADDR_FUNC, f);
    repeat (3) @(posedge ref_clk);
    #1;
    `CHK(lamps[i], e)
  endtask
  task automatic win(input int settle, input int n);
    repeat (settle) @(posedge ref_clk);
    clear <= 1'b1;
    @(posedge ref_clk);
    clear <= 1'b0;
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic std_codes(input logic [15:0] ev, input logic [15:0] mv);
    for (int c = 0; c < 16; c++) begin
      if (mv[c]) try({4'hf, c[3:0], c[3:0], 4'hf}, 1, ev[c]);
    end
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    print_verdict();
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(ADDR_MODE, 16'h0001);
    rd(ADDR_FUNC, 16'hf4f0);
    rd(ADDR_BLINK, 16'h1f55);
    wr(ADDR_MODE, 16'hffff);
    wr(5'h1e, 16'h0000);
    rd(ADDR_MODE, 16'hfcfd);
    rd(5'h1e, 16'h0000);
    wr(ADDR_MODE, 16'h8001);
    try(16'heeee, 3, 1'b0);
    `CHK(lamps[2], 1'b1)
    `CHK(lamps[1], 1'b1)
    wr(ADDR_MODE, 16'h4001);
    try(16'heeee, 1, 1'b0);
    `CHK(lamps[3], 1'b1)
    wr(ADDR_MODE, 16'h0001);
    status <= '{SPEED_1000, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    std_codes(16'h5d19, 16'hdfff);
    @(posedge ref_clk);
    status <= '{SPEED_100, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    std_codes(16'h4ab2, 16'hcbf7);
    wr(ADDR_MODE, 16'h0801);
    status <= '{SPEED_1000, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
    for (int c = 0; c < 3; c++) try({8'hf4, xc[c], 4'hf}, 2, c == 1);
    @(posedge ref_clk);
    status <= '{SPEED_100, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
    for (int c = 0; c < 3; c++) try({8'hf4, xc[c], 4'hf}, 2, c != 1);
    @(posedge ref_clk);
    status <= '0;
    wr(ADDR_FUNC, 16'h54ff);
    for (int k = 0; k < 5; k++) begin
      wr(ADDR_MODE, modes[k]);
      @(posedge ref_clk);
      clear <= 1'b1;
      status.tx_active <= 1'b1;
      @(posedge ref_clk);
      clear <= 1'b0;
      status.tx_active <= 1'b0;
      repeat (24) @(posedge ref_clk);
      #1;
      `CHK(on_cnt[0], holds[k])
    end
    // Gig copy blinks, fast copy held steady: copies must not bleed
    wr(ADDR_MODE, 16'h0001);
    wr(ADDR_BLINK, 16'h8001);
    rd(ADDR_BLINK, 16'h8001);
    wr(ADDR_BLINK, 16'hc0ff);
    wr(ADDR_FUNC, 16'hffdd);
    wr(ADDR_BLINK, 16'h8001);
    win(200, 64);
    `CHK(rise_cnt[3], 8'h04)
    `CHK(on_cnt[3], 8'h08)
    `CHK(on_cnt[2], 8'h40)
    wr(ADDR_BLINK, 16'h8101);
    win(200, 64);
    `CHK(rise_cnt[3], 8'h02)
    wr(ADDR_MODE, 16'h0041);
    wr(ADDR_BLINK, 16'h8001);
    win(200, 48);
    `CHK(rise_cnt[3], 8'h02)
    `CHK(on_cnt[3], 8'h04)
    print_verdict();
  end
endmodule
bind pli_led_ctrl pli_led_ctrl_chk i_chk (.ref_clk(ref_clk), .reset_n(reset_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .status(status), .lamps(lamps));
`default_nettype wire
